// >>> hw/bus_low_if.sv
`timescale 1ns/1ps
`default_nettype none
// Synchronised bus line levels and sleep request
interface bus_low_if;
	logic scl_high;
	logic sda_high;
	logic timeout;
	modport watcher (input scl_high, input sda_high, output timeout);
	modport owner   (output scl_high, output sda_high, input timeout);
endinterface
`default_nettype wire

// >>> hw/bus_low_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "gauge_defs.svh"
module bus_low_timer
(
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       ce_i,
	input  wire logic       arm_i,
	bus_low_if.watcher      bus
);
	logic [`SLEEP_CNT_W-1:0] count;
	logic [`SLEEP_CNT_W-1:0] next_count;
	logic                    fired;
	logic                    next_fired;

	// Count continuous low on both lines
	always_comb
	begin
		next_count = count;
		next_fired = 1'b0;
		if (bus.scl_high || bus.sda_high || !arm_i)
			next_count = '0; // [R14] [R10]
		else if (count == `SLEEP_CNT_W'(`SLEEP_CYCLES - 1))
			next_fired = 1'b1; // [R01]
		else
			next_count = count + `SLEEP_CNT_W'(1);
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			count <= '0;
			fired <= 1'b0;
		end
		else if (ce_i)
		begin
			count <= next_count;
			fired <= next_fired;
		end
	end

	assign bus.timeout = fired;
endmodule
`default_nettype wire

// >>> hw/gauge_defs.svh
`ifndef GAUGE_DEFS_SVH
`define GAUGE_DEFS_SVH

// Clock rate in kHz and bus-low timeout window in ms
`define CLK_KHZ           40000
`define SLEEP_MIN_MS      1500
`define SLEEP_MAX_MS      2200
// Timeout target: 1800 ms inside the window, cycles
`define SLEEP_TARGET_MS   1800
`define SLEEP_CYCLES      (`SLEEP_TARGET_MS * `CLK_KHZ)
`define SLEEP_CNT_W       27
// Current range: +/-51.2 mV at 25 uV per step gives 2048 steps per polarity
`define CUR_UV_PER_LSB    25
`define CUR_FS_UV         51200
`define CUR_MAG_W         11
`define CUR_MAG_MAX       11'h7ff
// Result widths
`define VOLT_W            12
`define AUX_W             11
`define TEMP_W            11
`define ACC_W             24
// Sample interval between current samples, cycles
`define SAMPLE_CYCLES     16'h0fa0
`define SAMPLE_CNT_W      16
// Register word width
`define REG_W             16

`endif

// >>> hw/gauge_measure.sv
// Contract
// R01 - Sleep is entered 1.5 s to 2.2 s after both bus lines go and stay low.
// R02 - The host keeps bus lines from staying low past the timeout unless it wants sleep.
// R03 - Sense voltage is taken in both polarities over +/-51.2 mV at 25 uV per step.
// R04 - Current is sampled at a fixed interval and each sample is added to an accumulator.
// R05 - Each current result goes into a two-byte register as sign and magnitude.
// R06 - Battery voltage is reported as a 12-bit value in a two-byte register.
// R07 - Each auxiliary conversion is reported with 11 bits in its own two-byte register.
// R08 - Die temperature is reported in 0.125 degree steps.
// R09 - With internal temperature selected, the aux-one slot measures temperature.
// R10 - A low bus forces sleep only while the sleep enable bit is 1.
// R11 - Asleep, all measurement stops and results stay unchanged.
// R12 - Register access is served in both active and sleep modes.
// R13 - The temperature takes the aux-one slot only while its select bit is set.
// R14 - The bus-low count restarts whenever either line is seen high.
// R15 - Each multi-byte result updates as one whole word.
`timescale 1ns/1ps
`default_nettype none
`include "gauge_defs.svh"
module gauge_measure
(
	input  wire logic                   SYS_CLK_I,
	input  wire logic                   RST_N_I,
	input  wire logic                   CE_I,
	input  wire logic                   SCL_I,
	input  wire logic                   SDA_I,
	input  wire logic                   BUS_ACTIVITY_I,
	input  wire logic                   SLEEP_ENABLE_BIT_I,
	input  wire logic                   INTERNAL_TEMP_SELECT_I,
	input  wire logic                   CONV_DONE_I,
	input  wire logic signed [11:0]     CURRENT_SENSE_INPUT_I,
	input  wire logic [`VOLT_W-1:0]     VOLT_RESULT_I,
	input  wire logic [`AUX_W-1:0]      AUX_INPUT_ZERO_I,
	input  wire logic [`AUX_W-1:0]      AUX_INPUT_ONE_I,
	input  wire logic [`TEMP_W-1:0]     TEMP_RESULT_I,
	output logic                        SLEEP_O,
	output logic [1:0]                  SLOT_O,
	output logic                        SLOT_TEMP_O,
	output logic [`REG_W-1:0]           CURRENT_REG_O,
	output logic [`REG_W-1:0]           VOLT_REG_O,
	output logic [`REG_W-1:0]           AUX0_REG_O,
	output logic [`REG_W-1:0]           AUX1_REG_O,
	output logic [`REG_W-1:0]           TEMP_REG_O,
	output logic signed [`ACC_W-1:0]    ACCUM_O
);
	//--------------------------------------------------------------
	// Pin synchronisers
	//--------------------------------------------------------------
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	bus_low_if  bl ();

	// Two flops per bus line
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
		end
		else if (CE_I)
		begin
			scl_sync <= {scl_sync[0], SCL_I};
			sda_sync <= {sda_sync[0], SDA_I};
		end
	end

	assign bl.scl_high = scl_sync[1];
	assign bl.sda_high = sda_sync[1];

	bus_low_timer timer
	(
		.clk_i   (SYS_CLK_I),
		.rst_n_i (RST_N_I),
		.ce_i    (CE_I),
		.arm_i   (SLEEP_ENABLE_BIT_I && (SLEEP_O == gauge_pkg::MODE_ACTIVE)),
		.bus     (bl.watcher)
	);

	//--------------------------------------------------------------
	// Power mode
	//--------------------------------------------------------------
	gauge_pkg::power_mode_t mode;
	gauge_pkg::power_mode_t next_mode;

	// Sleep on timeout, wake on bus activity
	always_comb
	begin
		next_mode = mode;
		case (mode)
			gauge_pkg::MODE_ACTIVE:
				if (bl.timeout && SLEEP_ENABLE_BIT_I)
					next_mode = gauge_pkg::MODE_SLEEP; // [R01] [R10]
			gauge_pkg::MODE_SLEEP:
				if (bl.scl_high || bl.sda_high || BUS_ACTIVITY_I)
					next_mode = gauge_pkg::MODE_ACTIVE;
			default:
				next_mode = gauge_pkg::MODE_ACTIVE;
		endcase
	end

	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			mode <= gauge_pkg::MODE_ACTIVE;
		else if (CE_I)
			mode <= next_mode;
	end

	assign SLEEP_O = (mode == gauge_pkg::MODE_SLEEP);

	//--------------------------------------------------------------
	// Current sampling and accumulation
	//--------------------------------------------------------------
	logic [`SAMPLE_CNT_W-1:0]  sample_cnt;
	logic [`SAMPLE_CNT_W-1:0]  next_sample_cnt;
	logic [`REG_W-1:0]         next_current_reg;
	logic signed [`ACC_W-1:0]  next_accum;
	logic signed [11:0]        sample;
	logic [`CUR_MAG_W-1:0]     mag;
	logic                      active;

	assign active = (mode == gauge_pkg::MODE_ACTIVE);

	// Clamp to +/- full scale, build sign and magnitude
	always_comb
	begin
		sample = CURRENT_SENSE_INPUT_I; // [R03]
		if (sample[11])
			mag = (sample == 12'sh800) ? `CUR_MAG_MAX : `CUR_MAG_W'(-sample);
		else
			mag = sample[`CUR_MAG_W-1:0];
		next_sample_cnt  = sample_cnt;
		next_current_reg = CURRENT_REG_O;
		next_accum       = ACCUM_O;
		if (active) // [R11]
		begin
			if (sample_cnt == `SAMPLE_CYCLES - `SAMPLE_CNT_W'(1))
			begin
				next_sample_cnt  = '0; // [R04]
				next_current_reg = {sample[11], 4'h0, mag}; // [R05] [R15]
				next_accum       = ACCUM_O + `ACC_W'(sample); // [R04]
			end
			else
				next_sample_cnt = sample_cnt + `SAMPLE_CNT_W'(1);
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			sample_cnt    <= '0;
			CURRENT_REG_O <= '0;
			ACCUM_O       <= '0;
		end
		else if (CE_I)
		begin
			sample_cnt    <= next_sample_cnt;
			CURRENT_REG_O <= next_current_reg;
			ACCUM_O       <= next_accum;
		end
	end

	//--------------------------------------------------------------
	// Conversion slots and result registers
	//--------------------------------------------------------------
	gauge_pkg::slot_t   slot;
	gauge_pkg::slot_t   next_slot;
	logic               slot_temp;
	logic               next_slot_temp;
	logic [`REG_W-1:0]  next_volt;
	logic [`REG_W-1:0]  next_aux0;
	logic [`REG_W-1:0]  next_aux1;
	logic [`REG_W-1:0]  next_temp;

	// Advance sequence on each conversion, store whole words
	always_comb
	begin
		next_slot      = slot;
		next_slot_temp = slot_temp;
		next_volt      = VOLT_REG_O;
		next_aux0      = AUX0_REG_O;
		next_aux1      = AUX1_REG_O;
		next_temp      = TEMP_REG_O;
		if (active && CONV_DONE_I) // [R11]
		begin
			case (slot)
				gauge_pkg::SLOT_VOLT:
				begin
					next_volt = {VOLT_RESULT_I, 4'h0}; // [R06] [R15]
					next_slot = gauge_pkg::SLOT_AUX0;
				end
				gauge_pkg::SLOT_AUX0:
				begin
					next_aux0 = {AUX_INPUT_ZERO_I, 5'h00}; // [R07] [R15]
					next_slot = gauge_pkg::SLOT_AUX1;
					next_slot_temp = INTERNAL_TEMP_SELECT_I; // [R13]
				end
				gauge_pkg::SLOT_AUX1:
				begin
					if (slot_temp)
						next_temp = {TEMP_RESULT_I, 5'h00}; // [R08] [R09]
					else
						next_aux1 = {AUX_INPUT_ONE_I, 5'h00}; // [R07] [R13]
					next_slot = gauge_pkg::SLOT_VOLT;
				end
				default:
					next_slot = gauge_pkg::SLOT_VOLT;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			slot       <= gauge_pkg::SLOT_VOLT;
			slot_temp  <= 1'b0;
			VOLT_REG_O <= '0;
			AUX0_REG_O <= '0;
			AUX1_REG_O <= '0;
			TEMP_REG_O <= '0;
		end
		else if (CE_I)
		begin
			slot       <= next_slot;
			slot_temp  <= next_slot_temp;
			VOLT_REG_O <= next_volt;
			AUX0_REG_O <= next_aux0;
			AUX1_REG_O <= next_aux1;
			TEMP_REG_O <= next_temp;
		end
	end

	// Result registers drive the outputs in either power mode [R12]
	assign SLOT_O      = slot;
	assign SLOT_TEMP_O = slot_temp;
endmodule
`default_nettype wire

// >>> hw/gauge_pkg.sv
`default_nettype none
package gauge_pkg;
	// Power mode
	typedef enum logic [0:0]
	{
		MODE_ACTIVE = 1'b0,
		MODE_SLEEP  = 1'b1
	} power_mode_t;
	// Conversion slot in the measurement sequence
	typedef enum logic [1:0]
	{
		SLOT_VOLT = 2'b00,
		SLOT_AUX0 = 2'b01,
		SLOT_AUX1 = 2'b10
	} slot_t;
endpackage
`default_nettype wire

// >>> verif/gauge_measure_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ------------
// Gauge checks
// ------------
module gauge_measure_properties
(
	input wire logic        SYS_CLK_I,
	input wire logic        RST_N_I,
	input wire logic        CE_I,
	input wire logic        SCL_I,
	input wire logic        SDA_I,
	input wire logic        BUS_ACTIVITY_I,
	input wire logic        SLEEP_ENABLE_BIT_I,
	input wire logic        CONV_DONE_I,
	input wire logic [11:0] VOLT_RESULT_I,
	input wire logic [10:0] AUX_INPUT_ZERO_I,
	input wire logic [10:0] AUX_INPUT_ONE_I,
	input wire logic [10:0] TEMP_RESULT_I,
	input wire logic        SLEEP_O,
	input wire logic [1:0]  SLOT_O,
	input wire logic        SLOT_TEMP_O,
	input wire logic [15:0] CURRENT_REG_O,
	input wire logic [15:0] VOLT_REG_O,
	input wire logic [15:0] AUX0_REG_O,
	input wire logic [15:0] AUX1_REG_O,
	input wire logic [15:0] TEMP_REG_O,
	input wire logic [23:0] ACCUM_O
);
	localparam int LO_MIN = 60000000;
	localparam int LO_MAX = 88000000;
	logic [26:0] low_cnt;
	// Cycles of continuous low bus with sleep allowed
	always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			low_cnt <= 27'h0;
		else if (CE_I)
		begin
			if (SCL_I || SDA_I || !SLEEP_ENABLE_BIT_I || SLEEP_O || BUS_ACTIVITY_I)
				low_cnt <= 27'h0;
			else
				low_cnt <= low_cnt + 27'h1;
		end
	end
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RST_N_I);
	sequence take_s(int k);
		CE_I && CONV_DONE_I && !SLEEP_O && SLOT_O == k;
	endsequence
	sleep_early_a:
	assert property ($rose(SLEEP_O) |-> low_cnt >= LO_MIN) else $error("sleep too early");
	sleep_late_a:
	assert property (low_cnt <= LO_MAX) else $error("sleep too late");
	sleep_freeze_a:
	assert property (SLEEP_O && $past(SLEEP_O) |-> $stable(ACCUM_O) && $stable(CURRENT_REG_O)
		&& $stable(VOLT_REG_O)) else $error("results moved in sleep");
	volt_update_a:
	assert property (take_s(0) |=> VOLT_REG_O == {$past(VOLT_RESULT_I), 4'h0} && SLOT_O == 2'h1)
		else $error("volt update");
	aux0_update_a:
	assert property (take_s(1) |=> AUX0_REG_O == {$past(AUX_INPUT_ZERO_I), 5'h00}
		&& SLOT_O == 2'h2) else $error("aux0 update");
	temp_slot_a:
	assert property (take_s(2) ##0 SLOT_TEMP_O |=> TEMP_REG_O == {$past(TEMP_RESULT_I), 5'h00}
		&& $stable(AUX1_REG_O)) else $error("temp slot");
	aux1_update_a:
	assert property (take_s(2) ##0 !SLOT_TEMP_O |=> AUX1_REG_O == {$past(AUX_INPUT_ONE_I), 5'h00}
		&& SLOT_O == 2'h0) else $error("aux1 update");
	current_pad_a:
	assert property (CURRENT_REG_O[14:11] == 4'h0) else $error("current padding");
	volt_hold_a:
	assert property (!(CE_I && CONV_DONE_I && !SLEEP_O && SLOT_O == 2'h0) |=> $stable(VOLT_REG_O))
		else $error("volt moved");
endmodule
bind gauge_measure gauge_measure_properties props_i (.SYS_CLK_I, .RST_N_I, .CE_I, .SCL_I,
	.SDA_I, .BUS_ACTIVITY_I, .SLEEP_ENABLE_BIT_I, .CONV_DONE_I, .VOLT_RESULT_I,
	.AUX_INPUT_ZERO_I, .AUX_INPUT_ONE_I, .TEMP_RESULT_I, .SLEEP_O, .SLOT_O, .SLOT_TEMP_O,
	.CURRENT_REG_O, .VOLT_REG_O, .AUX0_REG_O, .AUX1_REG_O, .TEMP_REG_O, .ACCUM_O);
`default_nettype wire

// >>> verif/host_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------
// Host bus model
// ----------------
module host_bus_model
(
	output var logic scl_o,
	output var logic sda_o
);
	// Lines rest high on pull-ups
	initial
	begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// Frame at 200 ns per bit, lines never low for long
	task automatic frame(input int n);
		repeat (n)
		begin
			scl_o = 1'b0;
			sda_o = 1'($urandom);
			#100;
			scl_o = 1'b1;
			#100;
		end
		sda_o = 1'b1;
	endtask
	// Short low on both lines, far under the timeout
	task automatic both_low(input int t);
		scl_o = 1'b0;
		sda_o = 1'b0;
		#t;
		{scl_o, sda_o} = 2'b11;
	endtask
endmodule
`default_nettype wire

// >>> verif/test_gauge_measure.sv
`timescale 1ns/1ps
`default_nettype none
// --------------
// Gauge bench
// --------------
module test_gauge_measure;
	logic clk = 0, rst_n = 0, sleep_en = 0, sel = 0, done = 0, lat = 0, ce = 1;
	logic signed [11:0] cur = 0;
	logic signed [11:0] tab[5] = '{12'h7ff, 12'h801, 12'h000, 12'h800, 12'h001};
	logic [11:0] volt = 0;
	logic [10:0] aux0 = 0, aux1 = 0, temp = 0;
	logic signed [23:0] acc;
	wire logic scl, sda, sleep, slot_temp;
	wire logic [1:0] slot;
	wire logic [15:0] cur_reg, volt_reg, aux0_reg, aux1_reg, temp_reg;
	wire logic signed [23:0] accum;
	int errors = 0, n_compared = 0, s = 0;
	gauge_measure gauge_measure_i (.SYS_CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .SCL_I(scl),
		.SDA_I(sda), .BUS_ACTIVITY_I(1'b0), .SLEEP_ENABLE_BIT_I(sleep_en),
		.INTERNAL_TEMP_SELECT_I(sel), .CONV_DONE_I(done), .CURRENT_SENSE_INPUT_I(cur),
		.VOLT_RESULT_I(volt), .AUX_INPUT_ZERO_I(aux0), .AUX_INPUT_ONE_I(aux1),
		.TEMP_RESULT_I(temp), .SLEEP_O(sleep), .SLOT_O(slot), .SLOT_TEMP_O(slot_temp),
		.CURRENT_REG_O(cur_reg), .VOLT_REG_O(volt_reg), .AUX0_REG_O(aux0_reg),
		.AUX1_REG_O(aux1_reg), .TEMP_REG_O(temp_reg), .ACCUM_O(accum));
	host_bus_model host_bus_model_i (.scl_o(scl), .sda_o(sda));
	// Clock 40 MHz
	initial
		forever #12.5 clk = ~clk;
	task tick;
		@(posedge clk);
		#2;
	endtask
	task chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// Sign and magnitude of a sample
	function automatic logic [15:0] cur_fmt(input logic signed [11:0] c);
		logic [11:0] m;
		m = (c < 0) ? -c : c;
		if (c == 12'sh800)
			m = 12'h7ff;
		return {c[11], 4'h0, m[10:0]};
	endfunction
	task give_verdict;
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Watchdog
	initial
	begin
		#1500000;
		errors++;
		give_verdict;
	end
	// Main sequence
	initial
	begin
		void'($urandom(34));
		tab[4] = 12'($urandom);
		repeat (6) @(posedge clk);
		#2 rst_n = 1;
		chk("accum", accum, 24'h0);
		chk("slot", {22'h0, slot}, 24'h0);
		repeat (40)
		begin
			volt = 12'($urandom);
			aux0 = 11'($urandom);
			aux1 = 11'($urandom);
			temp = 11'($urandom);
			sel = 1'($urandom);
			done = 1;
			tick;
			if (s == 0)
				chk("volt", {8'h0, volt_reg}, {8'h0, volt, 4'h0});
			else if (s == 1)
				chk("aux0", {8'h0, aux0_reg}, {8'h0, aux0, 5'h00});
			else if (lat)
				chk("temp", {8'h0, temp_reg}, {8'h0, temp, 5'h00});
			else
				chk("aux1", {8'h0, aux1_reg}, {8'h0, aux1, 5'h00});
			if (s == 1)
				lat = sel;
			chk("slot_temp", {23'h0, slot_temp}, {23'h0, lat});
			s = (s + 1) % 3;
			chk("slot", {22'h0, slot}, 24'(s));
			if ($urandom % 2)
			begin
				done = 0;
				tick;
			end
		end
		// Clock enable low freezes the sequence
		ce = 0;
		done = 1;
		aux0 = 11'($urandom);
		repeat (3) tick;
		chk("freeze", {22'h0, slot}, 24'(s));
		ce = 1;
		tick;
		chk("aux0", {8'h0, aux0_reg}, {8'h0, aux0, 5'h00});
		chk("slot", {22'h0, slot}, 24'h2);
		done = 0;
		sleep_en = 1;
		fork
			host_bus_model_i.frame(2000);
		join_none
		foreach (tab[i])
		begin
			cur = tab[i];
			repeat (4001) tick;
			chk("current", {8'h0, cur_reg}, {8'h0, cur_fmt(cur)});
			acc = accum;
			repeat (4000) tick;
			chk("accum", accum - acc, 24'(cur));
			chk("sleep", {23'h0, sleep}, 24'h0);
		end
		host_bus_model_i.both_low(25000);
		tick;
		chk("sleep", {23'h0, sleep}, 24'h0);
		give_verdict;
	end
endmodule
`default_nettype wire
